// file: core/sfmt_pkg.sv
// package of constants and carrier types for the serial audio input formatter
package sfmt_pkg;
    // framing modes
    typedef enum logic [1:0] {
        SFMT_I2S = 2'b00,
        SFMT_LJ = 2'b01,
        SFMT_RJ = 2'b10
    } sfmt_mode_type;
    // word width selection
    typedef enum logic [1:0] {
        SFMT_W16 = 2'b00,
        SFMT_W18 = 2'b01,
        SFMT_W20 = 2'b10,
        SFMT_W24 = 2'b11
    } sfmt_width_type;
    localparam int SFMT_DATA_W = 24;
    localparam int SFMT_CNT_W = 6;
    localparam logic [SFMT_CNT_W-1:0] SFMT_BITS_16 = 6'h10;
    localparam logic [SFMT_CNT_W-1:0] SFMT_BITS_18 = 6'h12;
    localparam logic [SFMT_CNT_W-1:0] SFMT_BITS_20 = 6'h14;
    localparam logic [SFMT_CNT_W-1:0] SFMT_BITS_24 = 6'h18;
    // right-justified delays from channel-select edge to msb, in bit clocks
    localparam logic [SFMT_CNT_W-1:0] SFMT_RJD_16 = 6'h10;
    localparam logic [SFMT_CNT_W-1:0] SFMT_RJD_18 = 6'h0e;
    localparam logic [SFMT_CNT_W-1:0] SFMT_RJD_20 = 6'h0c;
    localparam logic [SFMT_CNT_W-1:0] SFMT_RJD_24 = 6'h08;
    localparam logic [SFMT_CNT_W-1:0] SFMT_I2SD = 6'h01;
    localparam logic [SFMT_CNT_W-1:0] SFMT_LJD = 6'h00;
    localparam int SFMT_BCLK_PER_CH = 32;
    // configuration and sample carriers
    typedef struct packed {
        sfmt_mode_type mode;
        sfmt_width_type width;
    } sfmt_cfg_type;
    typedef struct packed {
        logic left;
        logic [SFMT_DATA_W-1:0] data;
    } sfmt_sample_type;
endpackage

// file: core/sfmt_sync.sv
// two-flop synchroniser for a multi-bit level group
`timescale 1ns/10ps
`default_nettype none
module sfmt_sync #(
    parameter int W = 1
) (
    // clock
    input wire logic clock,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sfmt_sync_st_type;
    sfmt_sync_st_type st_q, st_d;
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge clock) begin
        st_q <= st_d;
    end
    assign q = st_q.s2;
endmodule
`default_nettype wire

// file: core/sfmt_formatter.sv
// serial audio input formatter: i2s, left- and right-justified word capture
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - three framings, widths 16/18/20/24
// - data captured on bit clock rising edge
// - right-justified: select high means left
// - right-justified msb delay 16/14/12/8 clocks
// - right-justified assumes 64 clocks per frame
// - i2s framing is the reset default
// - i2s: select low means left
// - i2s msb one clock after edge
// - left-justified: select high means left
// - left-justified msb with no delay
module sfmt_formatter (
    // system clock and reset
    input wire logic clock,
    input wire logic resetn,
    // configuration, system domain
    input wire sfmt_pkg::sfmt_cfg_type cfg,
    // serial link, bit clock domain
    input wire logic bclk,
    input wire logic lrclk,
    input wire logic sdata,
    // sample output to the encoder, system domain
    output sfmt_pkg::sfmt_sample_type sample,
    output logic sample_valid
);
    import sfmt_pkg::*;

    // ---------------- system domain: configuration ----------------
    typedef struct packed {
        sfmt_cfg_type cfg;
        logic rst_req;
    } sfmt_sys_type;
    sfmt_sys_type sys_q, sys_d;

    // ---------------- link domain state ----------------
    typedef struct packed {
        logic lr_prev;
        logic [SFMT_CNT_W-1:0] cnt;
        logic [SFMT_CNT_W-1:0] got;
        logic [SFMT_DATA_W-1:0] shreg;
        logic ch_left;
        sfmt_sample_type word;
        logic tgl;
    } sfmt_lnk_type;
    sfmt_lnk_type lnk_q, lnk_d;

    // ---------------- system domain: output side ----------------
    typedef struct packed {
        logic [2:0] tgl_sync;
        sfmt_sample_type word_s1;
        sfmt_sample_type word_s2;
        sfmt_sample_type sample;
        logic valid;
    } sfmt_out_type;
    sfmt_out_type out_q, out_d;

    sfmt_cfg_type cfg_l;
    logic rst_l;
    logic [SFMT_CNT_W-1:0] bits;
    logic [SFMT_CNT_W-1:0] delay;
    logic lr_edge;
    logic left_now;

    always_comb begin
        sys_d = sys_q;
        sys_d.cfg = cfg;
        // reset travels to the link as a level, so it also clears state that starts unknown
        sys_d.rst_req = !resetn;
        if (!resetn) begin
            sys_d.cfg.mode = SFMT_I2S;
            sys_d.cfg.width = SFMT_W24;
        end
    end

    always_ff @(posedge clock) begin
        sys_q <= sys_d;
    end

    // configuration is a slowly changing level; a change mid-word corrupts that word only
    sfmt_sync #(
        .W($bits(sfmt_cfg_type) + 1)
    ) u_cfg_sync (
        .clock(bclk),
        .d({sys_q.cfg, sys_q.rst_req}),
        .q({cfg_l, rst_l})
    );

    // per-width word length; msb delay per width for right-justified, fixed per mode for i2s and left-justified
    always_comb begin
        case (cfg_l.width)
            SFMT_W16: begin
                bits = SFMT_BITS_16;
                delay = SFMT_RJD_16;
            end
            SFMT_W18: begin
                bits = SFMT_BITS_18;
                delay = SFMT_RJD_18;
            end
            SFMT_W20: begin
                bits = SFMT_BITS_20;
                delay = SFMT_RJD_20;
            end
            default: begin
                bits = SFMT_BITS_24;
                delay = SFMT_RJD_24;
            end
        endcase
        case (cfg_l.mode)
            SFMT_I2S: delay = SFMT_I2SD;
            SFMT_LJ: delay = SFMT_LJD;
            default: ;
        endcase
    end

    // lrclk and sdata are sampled directly on the rising edge; the source
    // times them to that edge, so no synchroniser is wanted here
    assign lr_edge = lrclk != lnk_q.lr_prev;
    assign left_now = (cfg_l.mode == SFMT_I2S) ? ~lrclk : lrclk;

    always_comb begin
        lnk_d = lnk_q;
        lnk_d.lr_prev = lrclk;
        if (lr_edge) begin
            // the edge cycle itself is bit period 0
            lnk_d.cnt = 6'h01;
            lnk_d.got = '0;
            lnk_d.ch_left = left_now;
            if (delay == SFMT_LJD) begin
                lnk_d.shreg = {{(SFMT_DATA_W-1){1'b0}}, sdata};
                lnk_d.got = 6'h01;
            end
        end else begin
            if (lnk_q.cnt != 6'h3f) begin
                lnk_d.cnt = lnk_q.cnt + 6'h01;
            end
            if (lnk_q.cnt >= delay && lnk_q.got < bits) begin
                lnk_d.shreg = {lnk_q.shreg[SFMT_DATA_W-2:0], sdata};
                lnk_d.got = lnk_q.got + 6'h01;
            end
        end
        // word complete: left-align msb into the 24-bit carrier
        if (lnk_d.got == bits && lnk_q.got != bits) begin
            lnk_d.word.left = lnk_d.ch_left;
            lnk_d.word.data = lnk_d.shreg << (SFMT_BITS_24 - bits);
            lnk_d.tgl = ~lnk_q.tgl;
        end
        // link reset drops any partial word and parks the toggle at a known level
        if (rst_l) begin
            lnk_d.lr_prev = lrclk;
            lnk_d.got = bits;
            lnk_d.cnt = 6'h3f;
            lnk_d.tgl = 1'b0;
        end
    end

    always_ff @(posedge bclk) begin
        lnk_q <= lnk_d;
    end

    // word crosses by toggle handshake; it is stable for a whole word time
    always_comb begin
        out_d = out_q;
        out_d.tgl_sync = {out_q.tgl_sync[1:0], lnk_q.tgl};
        out_d.word_s1 = lnk_q.word;
        out_d.word_s2 = out_q.word_s1;
        out_d.valid = out_q.tgl_sync[2] != out_q.tgl_sync[1];
        if (out_d.valid) begin
            out_d.sample = out_q.word_s2;
        end
        // the link clears its toggle within the reset time, so both ends agree on release
        if (!resetn) begin
            out_d.tgl_sync = '0;
            out_d.valid = 1'b0;
            out_d.sample = '0;
        end
    end

    always_ff @(posedge clock) begin
        out_q <= out_d;
    end

    assign sample = out_q.sample;
    assign sample_valid = out_q.valid;
endmodule
`default_nettype wire

// file: tb/sfmt_source.sv
// serial audio source model
`timescale 1ns/10ps
`default_nettype none
module sfmt_source
    import sfmt_pkg::*;
(
    // framing in use
    input wire sfmt_pkg::sfmt_cfg_type cfg,
    // serial link
    output logic bclk,
    output logic lrclk,
    output logic sdata
);
    initial begin
        bclk = 1'b0;
        lrclk = 1'b0;
        sdata = 1'b0;
    end
    always #15 bclk = ~bclk;
    // one half frame of 32 bit clocks; idle bits toggle so stale data never looks valid
    task automatic send_half(input logic [23:0] w);
        int n, d, b;
        n = 16 + 2 * int'(cfg.width) + (cfg.width == SFMT_W24 ? 2 : 0);
        d = cfg.mode == SFMT_I2S ? 1 : cfg.mode == SFMT_LJ ? 0 : 32 - n;
        for (int p = 0; p < 32; p++) begin
            @(negedge bclk);
            if (p == 0) lrclk = ~lrclk;
            b = p - d;
            sdata = (b >= 0 && b < n) ? w[n - 1 - b] : ~sdata;
        end
    endtask
    // closing select edge, so a right-justified last word ends on a transition
    task automatic close_half();
        @(negedge bclk);
        lrclk = ~lrclk;
    endtask
endmodule
`default_nettype wire

// file: tb/sfmt_formatter_assertions.sv
// port checks for the formatter
`timescale 1ns/10ps
`default_nettype none
module sfmt_formatter_assertions
    import sfmt_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // link and configuration
    input wire sfmt_pkg::sfmt_cfg_type cfg,
    input wire logic lrclk,
    // sample output
    input wire sfmt_pkg::sfmt_sample_type sample,
    input wire logic sample_valid
);
    logic last_q, seen_q;
    logic [23:0] low;
    assign low = 24'h00_00ff >> (2 * cfg.width + (cfg.width == SFMT_W24 ? 2 : 0));
    always_ff @(posedge clock) begin
        if (!resetn) begin
            seen_q <= 1'b0;
            last_q <= 1'b0;
        end else if (sample_valid) begin
            seen_q <= 1'b1;
            last_q <= sample.left;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_quiet;
        !sample_valid [*8];
    endsequence
    property p_gap; sample_valid |=> s_quiet; endproperty
    a_gap: assert property (p_gap) else $error("valid pulses too close");
    property p_hold; !sample_valid |-> $stable(sample); endproperty
    a_hold: assert property (p_hold) else $error("sample moved without valid");
    property p_rst; disable iff (1'b0) !resetn |=> !sample_valid && sample == '0; endproperty
    a_rst: assert property (p_rst) else $error("output not cleared by reset");
    property p_low; sample_valid |-> (sample.data & low) == '0; endproperty
    a_low: assert property (p_low) else $error("bits below word not zero");
    property p_i2s; sample_valid && cfg.mode == SFMT_I2S |-> sample.left == !lrclk; endproperty
    a_i2s: assert property (p_i2s) else $error("channel tag wrong");
    property p_lj; sample_valid && cfg.mode == SFMT_LJ |-> sample.left == lrclk; endproperty
    a_lj: assert property (p_lj) else $error("channel tag wrong");
    // the select has already turned when a right-justified word lands
    property p_rj; sample_valid && cfg.mode == SFMT_RJ |-> sample.left == !lrclk; endproperty
    a_rj: assert property (p_rj) else $error("channel tag wrong");
    property p_alt; sample_valid && seen_q |-> sample.left != last_q; endproperty
    a_alt: assert property (p_alt) else $error("channels did not alternate");
endmodule
bind sfmt_formatter sfmt_formatter_assertions u_chk
    (.clock, .resetn, .cfg, .lrclk, .sample, .sample_valid);
`default_nettype wire

// file: tb/sfmt_formatter_bench.sv
// self-checking bench for the formatter
`timescale 1ns/10ps
`default_nettype none
module sfmt_formatter_bench;
    import sfmt_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    sfmt_cfg_type cfg = '0;
    logic bclk, lrclk, sdata, sample_valid;
    sfmt_sample_type sample, exp_q[$];
    int n_fail = 0;
    int cmp_count = 0;
    always #10 clock = ~clock;
    sfmt_formatter u_dut (.clock, .resetn, .cfg, .bclk, .lrclk, .sdata, .sample, .sample_valid);
    sfmt_source u_src (.cfg, .bclk, .lrclk, .sdata);
    task automatic check(input sfmt_sample_type seen, input sfmt_sample_type want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic test_done();
        if (exp_q.size() != 0) n_fail++;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock) begin
        if (sample_valid === 1'b1) begin
            if (exp_q.size() == 0) check(sample, 'x);
            else check(sample, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        n_fail++;
        test_done();
    end
    // every framing and width, each after its own reset
    initial begin
        logic [23:0] w;
        sfmt_sample_type e;
        int n;
        void'($urandom(32'hd099));
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge clock) #2;
                resetn = 1'b0;
                cfg = '{sfmt_mode_type'(m), sfmt_width_type'(k)};
                repeat (6) @(posedge clock);
                #2 resetn = 1'b1;
                repeat (8) @(posedge bclk);
                n = 16 + 2 * k + (k == 3 ? 2 : 0);
                repeat (4) begin
                    w = $urandom() >> (32 - n);
                    e.data = w << (24 - n);
                    e.left = (lrclk == (m == 0));
                    exp_q.push_back(e);
                    u_src.send_half(w);
                end
                u_src.close_half();
                repeat (10) @(posedge clock);
            end
        end
        test_done();
    end
endmodule
`default_nettype wire
